// ### hdl/fne_master_error.sv
// Contract
// - stopped PLC clears outputs, link keeps running
// - abnormal station: inputs cleared, outputs, link continue
// - unpowered station: inputs cleared, outputs continue
// - one bit per error, 1 means present
// - bit0 is OR of link maps, self-clearing
// - bit1 set on all-station link error, self-clearing
// - bit2 is OR of remote I/O maps
// - bit3 unregistered station, cleared by reset only
// - blown fuse appears only as all-station error
//
// Chosen here: the plain strobed port.
module fne_master_error
	import fne_pkg::*;
#(
	parameter int N = FNE_STATIONS,
	parameter int IO_W = FNE_IO_W
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [FNE_AW-1:0] reg_addr,
	input wire logic [FNE_DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [FNE_DW-1:0] reg_rdata,
	input wire logic [N-1:0] st_link_err,
	input wire logic all_link_err,
	input wire logic [N-1:0] st_rio_err,
	input wire logic [N-1:0] st_power_lost,
	input wire logic [N-1:0] st_connected,
	input wire logic plc_stopped,
	input wire logic [N*IO_W-1:0] st_in_data,
	input wire logic [N*IO_W-1:0] cpu_out_data,
	output logic [N*IO_W-1:0] in_image,
	output logic [N*IO_W-1:0] link_out_data,
	output logic link_run,
	output logic irq
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [N-1:0][FNE_DW-1:0] reg_tab;
		logic [FNE_MAP_WORDS-1:0][FNE_DW-1:0] link_map;
		logic [FNE_MAP_WORDS-1:0][FNE_DW-1:0] rio_map;
		logic [FNE_DW-1:0] detail;
		logic range_err;
		logic [FNE_DW-1:0] rdata;
		logic link_run;
	} fne_main_type;

	fne_main_type main_r;
	fne_main_type main_nxt;

	logic [FNE_EVENTS-1:0] irq_status;
	logic [FNE_EVENTS-1:0] irq_mask;
	logic irq_q;
	logic stat_rd;
	logic mask_wr;
	logic [5:0] tab_idx;
	logic [1:0] map_idx;
	logic tab_hit;

	assign tab_idx = 6'(reg_addr - FNE_ADR_TABLE_LO);
	assign map_idx = 2'(reg_addr);
	// a smaller build holds fewer entries: addresses past them act as unmapped
	assign tab_hit = (reg_addr >= FNE_ADR_TABLE_LO) && (reg_addr <= FNE_ADR_TABLE_HI) && (int'(tab_idx) < N);
	assign stat_rd = reg_rd && (reg_addr == FNE_ADR_IRQ_STATUS);
	assign mask_wr = reg_wr && (reg_addr == FNE_ADR_IRQ_MASK);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		main_nxt = main_r;
		main_nxt.link_run = 1'b1;
		main_nxt.link_map = (FNE_MAP_WORDS*FNE_DW)'(st_link_err);
		main_nxt.rio_map = (FNE_MAP_WORDS*FNE_DW)'(st_rio_err);

		if (reg_wr && tab_hit)
		begin
			main_nxt.reg_tab[tab_idx] = reg_wdata;
		end

		// an empty table entry means the station is not registered
		for (int i = 0; i < N; i++)
		begin
			if (st_connected[i] && (main_r.reg_tab[i] == FNE_TABLE_RST))
			begin
				main_nxt.range_err = 1'b1;
			end
		end

		main_nxt.detail = FNE_DETAIL_RST;
		main_nxt.detail[FNE_BIT_LINK_SOME] = |st_link_err;
		// no fuse monitor: a blown fuse is only visible through this bit
		main_nxt.detail[FNE_BIT_LINK_ALL] = all_link_err;
		main_nxt.detail[FNE_BIT_REMOTE_IO] = |st_rio_err;
		main_nxt.detail[FNE_BIT_OUT_OF_RANGE] = main_nxt.range_err;

		main_nxt.rdata = FNE_RDATA_IDLE;
		if (reg_rd)
		begin
			if (reg_addr == FNE_ADR_DETAIL_WORD)
			begin
				main_nxt.rdata = main_r.detail;
			end
			else if (reg_addr >= FNE_ADR_LINK_MAP && reg_addr <= FNE_ADR_LINK_MAP_HI)
			begin
				main_nxt.rdata = main_r.link_map[map_idx];
			end
			else if (reg_addr >= FNE_ADR_RIO_MAP && reg_addr <= FNE_ADR_RIO_MAP_HI)
			begin
				main_nxt.rdata = main_r.rio_map[map_idx];
			end
			else if (reg_addr == FNE_ADR_IRQ_STATUS)
			begin
				main_nxt.rdata = {{(FNE_DW-FNE_EVENTS){1'b0}}, irq_status};
			end
			else if (reg_addr == FNE_ADR_IRQ_MASK)
			begin
				main_nxt.rdata = {{(FNE_DW-FNE_EVENTS){1'b0}}, irq_mask};
			end
			else if (tab_hit)
			begin
				main_nxt.rdata = main_r.reg_tab[tab_idx];
			end
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			// only a reset clears the out-of-range flag
			main_r <= '0;
		end
		else
		begin
			main_r <= main_nxt;
		end
	end

	// ----------------------------------------------------------------
	// station data gating and error events
	// ----------------------------------------------------------------
	fne_station_gate #(
		.N(N),
		.W(IO_W)
	) u_gate (
		.clk(clk),
		.resetn(resetn),
		.st_in_data(st_in_data),
		.st_abnormal(st_link_err | st_rio_err | st_power_lost),
		.cpu_out_data(cpu_out_data),
		.plc_stopped(plc_stopped),
		.in_image(in_image),
		.link_out_data(link_out_data)
	);

	fne_event_irq #(
		.W(FNE_EVENTS)
	) u_irq (
		.clk(clk),
		.resetn(resetn),
		.ev_level(main_r.detail[FNE_EVENTS-1:0]),
		.stat_rd(stat_rd),
		.mask_wr(mask_wr),
		.mask_wdata(reg_wdata[FNE_EVENTS-1:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq_q)
	);

	assign reg_rdata = main_r.rdata;
	assign link_run = main_r.link_run;
	assign irq = irq_q;

endmodule

// ### include/fne_pkg.sv
package fne_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int FNE_STATIONS = 64;
	localparam int FNE_DW = 16;
	localparam int FNE_AW = 7;
	localparam int FNE_IO_W = 4;
	localparam int FNE_MAP_WORDS = 4;
	localparam int FNE_EVENTS = 4;

	// ----------------------------------------------------------------
	// register offsets (word addresses)
	// ----------------------------------------------------------------
	localparam logic [6:0] FNE_ADR_LINK_MAP = 7'h04;
	localparam logic [6:0] FNE_ADR_LINK_MAP_HI = 7'h07;
	localparam logic [6:0] FNE_ADR_RIO_MAP = 7'h08;
	localparam logic [6:0] FNE_ADR_RIO_MAP_HI = 7'h0b;
	localparam logic [6:0] FNE_ADR_DETAIL_WORD = 7'h1d;
	localparam logic [6:0] FNE_ADR_IRQ_STATUS = 7'h1e;
	localparam logic [6:0] FNE_ADR_IRQ_MASK = 7'h1f;
	localparam logic [6:0] FNE_ADR_TABLE_LO = 7'h20;
	localparam logic [6:0] FNE_ADR_TABLE_HI = 7'h5f;

	// ----------------------------------------------------------------
	// detailed_error_word bit positions
	// ----------------------------------------------------------------
	localparam int FNE_BIT_LINK_SOME = 0;
	localparam int FNE_BIT_LINK_ALL = 1;
	localparam int FNE_BIT_REMOTE_IO = 2;
	localparam int FNE_BIT_OUT_OF_RANGE = 3;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] FNE_DETAIL_RST = 16'h0000;
	localparam logic [15:0] FNE_TABLE_RST = 16'h0000;
	localparam logic [15:0] FNE_RDATA_IDLE = 16'h0000;
	localparam logic [3:0] FNE_MASK_RST = 4'h0;

endpackage

// ### hdl/fne_event_irq.sv
module fne_event_irq
	import fne_pkg::*;
#(
	parameter int W = FNE_EVENTS
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [W-1:0] ev_level,
	input wire logic stat_rd,
	input wire logic mask_wr,
	input wire logic [W-1:0] mask_wdata,
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);

	typedef struct packed {
		logic [W-1:0] prev;
		logic [W-1:0] status;
		logic [W-1:0] mask;
		logic irq;
	} fne_irq_type;

	fne_irq_type irq_r;
	fne_irq_type irq_nxt;

	always_comb
	begin
		irq_nxt = irq_r;
		irq_nxt.prev = ev_level;
		// a new rising edge in the clearing cycle survives the clear
		irq_nxt.status = (stat_rd ? '0 : irq_r.status) | (ev_level & ~irq_r.prev);
		if (mask_wr)
		begin
			irq_nxt.mask = mask_wdata;
		end
		irq_nxt.irq = |(irq_nxt.status & irq_nxt.mask);
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_r <= '{prev: '0, status: '0, mask: W'(FNE_MASK_RST), irq: 1'b0};
		end
		else
		begin
			irq_r <= irq_nxt;
		end
	end

	assign status = irq_r.status;
	assign mask = irq_r.mask;
	assign irq = irq_r.irq;

endmodule

// ### hdl/fne_station_gate.sv
module fne_station_gate
	import fne_pkg::*;
#(
	parameter int N = FNE_STATIONS,
	parameter int W = FNE_IO_W
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [N*W-1:0] st_in_data,
	input wire logic [N-1:0] st_abnormal,
	input wire logic [N*W-1:0] cpu_out_data,
	input wire logic plc_stopped,
	output logic [N*W-1:0] in_image,
	output logic [N*W-1:0] link_out_data
);

	typedef struct packed {
		logic [N*W-1:0] in_image;
		logic [N*W-1:0] link_out;
	} fne_gate_type;

	fne_gate_type gate_r;
	fne_gate_type gate_nxt;
	logic [N*W-1:0] in_nxt;
	logic [N*W-1:0] out_nxt;

	genvar g;
	generate
		for (g = 0; g < N; g++)
		begin : g_station
			// abnormal or unpowered station: its inputs read as off
			assign in_nxt[g*W +: W] = st_abnormal[g] ? '0 : st_in_data[g*W +: W];
			// outputs continue for a faulty station, but all clear on a stopped plc
			assign out_nxt[g*W +: W] = plc_stopped ? '0 : cpu_out_data[g*W +: W];
		end
	endgenerate

	always_comb
	begin
		gate_nxt.in_image = in_nxt;
		gate_nxt.link_out = out_nxt;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gate_r <= '0;
		end
		else
		begin
			gate_r <= gate_nxt;
		end
	end

	assign in_image = gate_r.in_image;
	assign link_out_data = gate_r.link_out;

endmodule

// ### tb/fne_station_model.sv
module fne_station_model
	import fne_pkg::*;
#(
	parameter int N = FNE_STATIONS,
	parameter int W = FNE_IO_W
)
(
	input wire logic clk,
	input wire logic [N-1:0] st_link_err,
	input wire logic [N-1:0] st_power_lost,
	input wire logic [W-1:0] pattern,
	output logic [N*W-1:0] st_in_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [W-1:0] churn_r = '0;
	always_ff @(posedge clk)
		churn_r <= churn_r + W'(1);
	// a cut-off station sends nothing usable, so its line churns instead of holding
	always_comb
		for (int i = 0; i < N; i++)
			st_in_data[i*W +: W] = (st_link_err[i] | st_power_lost[i]) ? churn_r ^ W'(i) : pattern ^ W'(i);
endmodule

// ### tb/fne_master_error_properties.sv
module fne_master_error_properties
	import fne_pkg::*;
#(
	parameter int N = FNE_STATIONS,
	parameter int IO_W = FNE_IO_W
)
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic [FNE_AW-1:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [FNE_DW-1:0] reg_rdata,
	input wire logic [N-1:0] st_link_err,
	input wire logic all_link_err,
	input wire logic [N-1:0] st_rio_err,
	input wire logic [N-1:0] st_power_lost,
	input wire logic plc_stopped,
	input wire logic [N*IO_W-1:0] st_in_data,
	input wire logic [N*IO_W-1:0] cpu_out_data,
	input wire logic [N*IO_W-1:0] in_image,
	input wire logic [N*IO_W-1:0] link_out_data,
	input wire logic link_run
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	wire logic rd_w = reg_rd && reg_addr == FNE_ADR_DETAIL_WORD;
	wire logic bad0 = st_link_err[0] | st_rio_err[0] | st_power_lost[0];
	link_some_a: assert property (rd_w |=> reg_rdata[0] == $past(|st_link_err, 2))
		else $error("bit0 wrong");
	link_all_a: assert property (rd_w |=> reg_rdata[1] == $past(all_link_err, 2))
		else $error("bit1 wrong");
	rio_err_a: assert property (rd_w |=> reg_rdata[2] == $past(|st_rio_err, 2))
		else $error("bit2 wrong");
	undef_zero_a: assert property (rd_w |=> reg_rdata[15:4] == '0)
		else $error("spare bits set");
	out_clear_a: assert property (plc_stopped |=> link_out_data == '0)
		else $error("outputs not cleared");
	out_pass_a: assert property (resetn && !plc_stopped |=> link_out_data == $past(cpu_out_data))
		else $error("outputs not passed");
	link_keep_a: assert property ($past(resetn) |-> link_run)
		else $error("link stopped");
	in_gate_a: assert property (resetn |=> in_image[IO_W-1:0] == ($past(bad0) ? '0 : $past(st_in_data[IO_W-1:0])))
		else $error("input gate wrong");
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside read cycle");
endmodule
bind fne_master_error fne_master_error_properties #(.N(N), .IO_W(IO_W)) u_props (.clk, .resetn, .reg_addr,
	.reg_rd, .reg_rdata, .st_link_err, .all_link_err, .st_rio_err, .st_power_lost, .plc_stopped, .st_in_data,
	.cpu_out_data, .in_image, .link_out_data, .link_run);

// ### tb/fne_master_error_tb_top.sv
module fne_master_error_tb_top
	import fne_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int N = 4;
	localparam logic [6:0] DW = FNE_ADR_DETAIL_WORD;
	logic clk = 1'h0;
	logic resetn = 1'h0;
	logic [6:0] reg_addr = '0;
	logic [15:0] reg_wdata = '0, cpu_out_data = '0, reg_rdata, st_in_data, in_image, link_out_data;
	logic reg_wr = 1'h0, reg_rd = 1'h0, all_link_err = 1'h0, plc_stopped = 1'h0, link_run, irq;
	logic [N-1:0] st_link_err = '0, st_rio_err = '0, st_power_lost = '0, st_connected = '0;
	logic [3:0] pattern = 4'h5;
	int num_errors = 0, comparisons = 0;
	always #5 clk = ~clk;
	fne_master_error #(.N(N)) u_dut (.clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.st_link_err, .all_link_err, .st_rio_err, .st_power_lost, .st_connected, .plc_stopped, .st_in_data,
		.cpu_out_data, .in_image, .link_out_data, .link_run, .irq);
	fne_station_model #(.N(N)) u_st (.clk, .st_link_err, .st_power_lost, .pattern, .st_in_data);
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		comparisons++;
		if (s !== e)
		begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [6:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask
	task rd(input logic [6:0] a, input logic [15:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		#1;
		chk("rdata", reg_rdata, e);
	endtask
	task wait_n(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task do_reset;
		resetn <= 1'h0;
		repeat (5) @(posedge clk);
		resetn <= 1'h1;
		repeat (2) @(posedge clk);
	endtask
	task t_bits;
		wr(DW, 16'hffff);
		rd(DW, '0);
		rd(7'h10, '0);
		@(posedge clk);
		st_link_err <= 4'h4;
		rd(DW, 16'h0001);
		rd(FNE_ADR_LINK_MAP, 16'h0004);
		@(posedge clk);
		st_link_err <= '0;
		all_link_err <= 1'h1;
		rd(DW, 16'h0002);
		@(posedge clk);
		all_link_err <= 1'h0;
		st_rio_err <= 4'h2;
		rd(DW, 16'h0004);
		rd(FNE_ADR_RIO_MAP, 16'h0002);
		@(posedge clk);
		st_rio_err <= '0;
		rd(DW, '0);
		$display("t_bits done");
	endtask
	task t_irq;
		rd(FNE_ADR_IRQ_STATUS, 16'h0007);
		wr(FNE_ADR_IRQ_MASK, 16'h0004);
		@(posedge clk);
		st_link_err <= 4'h1;
		wait_n(4);
		chk("irq", irq, 1'h0);
		rd(FNE_ADR_IRQ_STATUS, 16'h0001);
		@(posedge clk);
		st_rio_err <= 4'h8;
		wait_n(4);
		chk("irq", irq, 1'h1);
		rd(FNE_ADR_IRQ_STATUS, 16'h0004);
		chk("irq", irq, 1'h0);
		@(posedge clk);
		st_link_err <= '0;
		st_rio_err <= '0;
		$display("t_irq done");
	endtask
	task t_data;
		@(posedge clk);
		cpu_out_data <= 16'h3c5a;
		st_power_lost <= 4'h3;
		wait_n(2);
		chk("out", link_out_data, 16'h3c5a);
		chk("in", in_image, 16'h6700);
		@(posedge clk);
		plc_stopped <= 1'h1;
		st_power_lost <= '0;
		st_link_err <= 4'h8;
		wait_n(2);
		chk("out", link_out_data, '0);
		chk("in", in_image, 16'h0745);
		chk("run", link_run, 1'h1);
		@(posedge clk);
		plc_stopped <= 1'h0;
		st_link_err <= '0;
		$display("t_data done");
	endtask
	task t_range;
		wr(FNE_ADR_TABLE_LO + 7'h01, 16'h0011);
		rd(FNE_ADR_TABLE_LO + 7'h01, 16'h0011);
		@(posedge clk);
		st_connected <= 4'h2;
		wait_n(2);
		rd(DW, '0);
		@(posedge clk);
		st_connected <= 4'h6;
		wait_n(2);
		rd(DW, 16'h0008);
		@(posedge clk);
		st_connected <= 4'h2;
		wr(FNE_ADR_TABLE_LO + 7'h02, 16'h0001);
		rd(DW, 16'h0008);
		@(posedge clk);
		st_connected <= '0;
		do_reset;
		rd(DW, '0);
		rd(FNE_ADR_TABLE_LO + 7'h01, '0);
		$display("t_range done");
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		num_errors++;
		tally_and_finish;
	end
	initial
	begin
		do_reset;
		t_bits;
		t_irq;
		t_data;
		t_range;
		tally_and_finish;
	end
endmodule
